// ===== src/pas_pkg.sv
// Purpose: Shared constants for the port analog select block.
// Assumes: Registers sit on a 32-bit classic Wishbone bus, one word each.
// Notes: Byte address of a register is four times its index.
package pas_pkg;
  localparam int ADR_W = 14;
  localparam int DAT_W = 32;
  localparam int SEL_W = 8;
  localparam logic [11:0] IDX_PORT_B = 12'hf39;
  localparam logic [11:0] IDX_PORT_C = 12'hf3a;
  localparam logic [11:0] IDX_PORT_D = 12'hf3b;
  localparam logic [7:0] MASK_PORT_B = 8'h3f;
  localparam logic [7:0] MASK_PORT_C = 8'hfc;
  localparam logic [7:0] MASK_PORT_D = 8'hff;
  localparam logic [7:0] RST_PORT_B = 8'h3f;
  localparam logic [7:0] RST_PORT_C = 8'hfc;
  localparam logic [7:0] RST_PORT_D = 8'hff;
endpackage

// ===== src/pas_sel_reg.sv
// Purpose: One eight-bit analog select register with an implemented-bit mask.
// Assumes: Write strobe is a single-cycle commit pulse.
// Notes: Unimplemented bits are held at zero regardless of writes.
`timescale 1ns/100ps
`default_nettype none
module pas_sel_reg #(
  parameter logic [7:0] MASK = 8'hff,
  parameter logic [7:0] RST_VAL = 8'hff
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] value_o
);
  logic [7:0] next_value;

  always_comb
  begin
    next_value = value_o;
    if (we_i)
    begin
      next_value = wdata_i & MASK;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      value_o <= RST_VAL & MASK;
    end
    else
    begin
      value_o <= next_value;
    end
  end
endmodule // pas_sel_reg
`default_nettype wire

// ===== src/pas_top.sv
// Purpose: Analog select registers for ports B, C and D behind Wishbone.
// Assumes: Synchronous active-high reset stands for power-on reset.
// Notes: A set bit disables the pin's digital input buffer.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module pas_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pas_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [pas_pkg::DAT_W-1:0] wb_dat_i,
  output logic [pas_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [7:0] port_b_input_disable_o,
  output logic [7:0] port_c_input_disable_o,
  output logic [7:0] port_d_input_disable_o
);
  import pas_pkg::*;

  logic [7:0] port_b_pin_analog_bits;
  logic [7:0] port_c_pin_analog_bits;
  logic [7:0] port_d_pin_analog_bits;
  logic [11:0] word_idx;
  logic commit;
  logic next_ack;
  logic [DAT_W-1:0] next_dat;
  logic we_b;
  logic we_c;
  logic we_d;

  // Register index decode, shared by the write strobes and the read mux.
  function automatic logic hit(input logic [11:0] idx, input logic [11:0] target);
    hit = (idx == target);
  endfunction

  assign word_idx = wb_adr_i[ADR_W-1:2];
  // Writes land on the edge where the master sees ack, as classic cycles require.
  assign commit = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign we_b = commit && hit(word_idx, IDX_PORT_B);
  assign we_c = commit && hit(word_idx, IDX_PORT_C);
  assign we_d = commit && hit(word_idx, IDX_PORT_D);

  // Each port keeps its own register so that its mask and reset value stay local to it.
  pas_sel_reg #(.MASK(MASK_PORT_B), .RST_VAL(RST_PORT_B)) u_port_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(we_b),
    .wdata_i(wb_dat_i[SEL_W-1:0]),
    .value_o(port_b_pin_analog_bits)
  );

  pas_sel_reg #(.MASK(MASK_PORT_C), .RST_VAL(RST_PORT_C)) u_port_c (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(we_c),
    .wdata_i(wb_dat_i[SEL_W-1:0]),
    .value_o(port_c_pin_analog_bits)
  );

  pas_sel_reg #(.MASK(MASK_PORT_D), .RST_VAL(RST_PORT_D)) u_port_d (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(we_d),
    .wdata_i(wb_dat_i[SEL_W-1:0]),
    .value_o(port_d_pin_analog_bits)
  );

  // The buffer controls are the register flops themselves, so they change on the write edge.
  assign port_b_input_disable_o = port_b_pin_analog_bits;
  assign port_c_input_disable_o = port_c_pin_analog_bits;
  assign port_d_input_disable_o = port_d_pin_analog_bits;

  // The answer comes one edge after the request is taken, and ack drops even if it is held.
  always_comb
  begin
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat = '0;
    if (next_ack && !wb_we_i)
    begin
      if (hit(word_idx, IDX_PORT_B))
      begin
        next_dat = {24'h000000, port_b_pin_analog_bits};
      end
      else if (hit(word_idx, IDX_PORT_C))
      begin
        next_dat = {24'h000000, port_c_pin_analog_bits};
      end
      else if (hit(word_idx, IDX_PORT_D))
      begin
        next_dat = {24'h000000, port_d_pin_analog_bits};
      end
      else
      begin
        next_dat = '0;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic unmapped;
  assign unmapped = !hit(word_idx, IDX_PORT_B) && !hit(word_idx, IDX_PORT_C)
    && !hit(word_idx, IDX_PORT_D);

  a_b_high_zero: assert property (port_b_pin_analog_bits[7:6] == 2'h0)
    else $error("Port B bits 7..6 not zero.");
  a_c_low_zero: assert property (port_c_pin_analog_bits[1:0] == 2'h0)
    else $error("Port C bits 1..0 not zero.");
  a_unmapped_read_zero: assert property (
    (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && unmapped) |=> (wb_ack_o && wb_dat_o == '0))
    else $error("Unmapped read returned nonzero.");
  a_reset_all_ones: assert property (@(posedge clk_i) $past(rst_i) && !rst_i |->
    (port_b_pin_analog_bits == RST_PORT_B && port_c_pin_analog_bits == RST_PORT_C
    && port_d_pin_analog_bits == RST_PORT_D))
    else $error("Select bits not one after reset.");
  a_write_b_update: assert property (we_b |=>
    port_b_input_disable_o == ($past(wb_dat_i[7:0]) & MASK_PORT_B))
    else $error("Port B write not applied.");
  a_write_c_update: assert property (we_c |=>
    port_c_input_disable_o == ($past(wb_dat_i[7:0]) & MASK_PORT_C))
    else $error("Port C write not applied.");
  a_write_d_update: assert property (we_d |=>
    port_d_input_disable_o == ($past(wb_dat_i[7:0]) & MASK_PORT_D))
    else $error("Port D write not applied.");
  a_hold_no_write: assert property (!we_d |=> $stable(port_d_input_disable_o))
    else $error("Port D changed without a write.");
  a_read_b_value: assert property (
    (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && hit(word_idx, IDX_PORT_B))
    |=> wb_dat_o[7:0] == port_b_input_disable_o)
    else $error("Port B read mismatch.");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack held for two cycles.");

  // Bus-side terms used by the handshake checks below.
  logic req_taken;
  logic read_taken;
  logic lane_off_write;
  assign req_taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign read_taken = req_taken && !wb_we_i;
  assign lane_off_write = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && !wb_sel_i[0];

  // Every taken request is answered on the very next edge, and never without one.
  a_ack_answers: assert property (req_taken |=> wb_ack_o)
    else $error("Request not acknowledged on the next edge.");
  a_ack_no_request: assert property (!req_taken |=> !wb_ack_o)
    else $error("Ack raised without a taken request.");
  // A master that leaves reset must find the bus quiet on its first edge.
  a_reset_bus_quiet: assert property (@(posedge clk_i) $past(rst_i) && !rst_i |->
    (!wb_ack_o && wb_dat_o == '0))
    else $error("Bus outputs not idle after reset.");

  // Read data is cleared between answers, so a stale byte cannot pass for a fresh one.
  a_dat_idle_zero: assert property (!read_taken |=> wb_dat_o == '0)
    else $error("Read data not zero outside a read answer.");
  a_dat_upper_zero: assert property (wb_dat_o[DAT_W-1:8] == '0)
    else $error("Read data above the low byte not zero.");
  // Reads of C and D return the live register, as the port B read does.
  a_read_c_value: assert property (read_taken && hit(word_idx, IDX_PORT_C)
    |=> wb_dat_o[7:0] == port_c_input_disable_o)
    else $error("Port C read mismatch.");
  a_read_d_value: assert property (read_taken && hit(word_idx, IDX_PORT_D)
    |=> wb_dat_o[7:0] == port_d_input_disable_o)
    else $error("Port D read mismatch.");

  // Outside a committed write the buffer controls must not move.
  a_hold_b_no_write: assert property (!we_b |=> $stable(port_b_input_disable_o))
    else $error("Port B changed without a write.");
  a_hold_c_no_write: assert property (!we_c |=> $stable(port_c_input_disable_o))
    else $error("Port C changed without a write.");
  // Committing at the taken edge instead of the acked one would let a write land early.
  a_no_early_write: assert property (req_taken |=>
    $stable(port_b_input_disable_o) && $stable(port_c_input_disable_o)
    && $stable(port_d_input_disable_o))
    else $error("Register changed before the acked edge.");
  // A write without the low byte lane still acks but must leave every register alone.
  a_lane_off_ignored: assert property (lane_off_write |=>
    $stable(port_b_input_disable_o) && $stable(port_c_input_disable_o)
    && $stable(port_d_input_disable_o))
    else $error("Write without the low lane changed a register.");
  // Writes to addresses with no register are acked and dropped.
  a_unmapped_write_ignored: assert property (
    (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && unmapped) |=>
    $stable(port_b_input_disable_o) && $stable(port_c_input_disable_o)
    && $stable(port_d_input_disable_o))
    else $error("Unmapped write changed a register.");

  // Covers for the main kinds of traffic.
  c_write_b: cover property (we_b);
  c_write_d_zero: cover property (we_d ##1 port_d_input_disable_o == 8'h00);
  c_read_c: cover property (wb_ack_o && !wb_we_i && hit(word_idx, IDX_PORT_C));
  c_read_unmapped: cover property (wb_ack_o && !wb_we_i && unmapped);
  c_write_lane_off: cover property (lane_off_write);
endmodule // pas_top
`default_nettype wire

// ===== test/tb_top.sv
// Purpose: Self-checking bench for the port analog select block.
// Assumes: Classic Wishbone single cycles, one register byte per word.
// Notes: An integer model holds what each register should read.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pas_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [13:0] adr = '0;
  logic [3:0] sel = '0;
  logic [31:0] wdat = '0, rdat, rd, lf = 32'h11f1;
  logic [7:0] ob, oc, od;
  int miscompares = 0, check_count = 0, cycles = 0, m[3];
  logic [11:0] ix[3] = '{IDX_PORT_B, IDX_PORT_C, IDX_PORT_D};
  logic [7:0] mk[3] = '{MASK_PORT_B, MASK_PORT_C, MASK_PORT_D};
  logic [11:0] bad[4] = '{12'hf38, 12'hf3c, 12'h000, 12'hfff};
  pas_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .port_b_input_disable_o(ob), .port_c_input_disable_o(oc), .port_d_input_disable_o(od));
  always #2.5 clk_i = ~clk_i;
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    lfsr_next = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // A hung handshake must still reach the verdict.
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      miscompares++;
      results();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  // Entered just after a rising edge; data is taken at the edge that sees ack.
  task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] d,
    input logic [3:0] s);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {24'h0, d};
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic look(input int k);
    bus(1'b0, ix[k], 8'h00, 4'hf);
    chk("read", 32'(m[k]), rd);
    chk("pins", 32'(m[k]), {24'h0, k == 0 ? ob : k == 1 ? oc : od});
  endtask
  task automatic put(input int k, input logic [7:0] d, input logic [3:0] s);
    bus(1'b1, ix[k], d, s);
    if (s[0])
      m[k] = int'(d & mk[k]);
  endtask
  task automatic fresh;
    for (int k = 0; k < 3; k++)
    begin
      m[k] = int'(mk[k]);
      look(k);
    end
  endtask
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    fresh();
    $display("test reset done");
    for (int i = 0; i < 36; i++)
    begin
      lf = lfsr_next(lf);
      put(i % 3, i < 6 ? {8{i[1]}} : lf[7:0], i < 6 ? 4'h1 : lf[11:8]);
      look(i % 3);
    end
    $display("test writes done");
    for (int j = 0; j < 4; j++)
    begin
      bus(1'b1, bad[j], 8'hff, 4'hf);
      bus(1'b0, bad[j], 8'h00, 4'hf);
      chk("unmapped", 32'h0, rd);
    end
    for (int k = 0; k < 3; k++)
      look(k);
    $display("test unmapped done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    fresh();
    $display("test second reset done");
    results();
  end
endmodule // tb_top
`default_nettype wire
